// ==== include/fault_sup_pkg.sv ====
// package: register map, defaults, fault codes and timing for the fault supervisor
package fault_sup_pkg;
	// timing
	localparam int CLK_PERIOD_NS  = 10;        // 100 MHz control clock
	localparam int MS_NS          = 1000000;   // one millisecond in ns
	localparam int MS_TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
	localparam int DIV_W          = 17;        // divider counter width
	localparam int DLY_W          = 14;        // millisecond settings width
	localparam int TMR_W          = 15;        // timer width (holds a sum)
	// thresholds
	localparam logic [7:0] CURRENT_MIN_PCT = 8'h19;  // 25 % of rated
	// setting reset values (ms, or 0.1 m/s2 for the level)
	localparam logic [13:0] START_DLY_RST  = 14'h00C8; // 200 ms
	localparam logic [13:0] RUN_DLY_RST    = 14'h00C8; // 200 ms
	localparam logic [13:0] RUN_DLY_MAX    = 14'h1388; // 5000 ms
	localparam logic [13:0] BRAKE_TIME_RST = 14'h01F4; // 500 ms
	localparam logic [13:0] BRAKE_TIME_MAX = 14'h2710; // 10000 ms
	localparam logic [13:0] OA_TIME_RST    = 14'h0032; // 50 ms
	localparam logic [13:0] OA_TIME_MAX    = 14'h1388; // 5000 ms
	localparam logic [7:0]  OA_LEVEL_STD   = 8'h0F;    // 1.5 m/s2
	localparam logic [7:0]  OA_LEVEL_ALT   = 8'h32;    // 5.0 m/s2
	localparam logic [7:0]  OA_LEVEL_MAX   = 8'hC8;    // 20.0 m/s2
	localparam logic [2:0]  UNIT_SEL_ALT   = 3'h6;     // unit choice giving alt level
	localparam logic [13:0] TIMING_A_RST   = 14'h03E8; // 1000 ms
	localparam logic [13:0] TIMING_B_RST   = 14'h012C; // 300 ms
	localparam logic [6:0]  MODE_RST       = 7'h02;    // ref loss on, rest 0
	// mode field positions
	localparam int MODE_OA_SEL   = 0;
	localparam int MODE_REF_EN   = 1;
	localparam int MODE_RESTART  = 2;
	localparam int MODE_SAFE_DIS = 3;
	localparam int MODE_UNIT_LSB = 4;
	// control bits (write one)
	localparam int CTRL_FAULT_CLR = 0;
	localparam int CTRL_PARAM_INIT = 1;
	localparam int CTRL_REC_CLR   = 2;
	// fault flag positions and codes
	localparam int FLT_N = 5;
	localparam int F_START = 0;
	localparam int F_RUN   = 1;
	localparam int F_BRAKE = 2;
	localparam int F_OACC  = 3;
	localparam int F_REF   = 4;
	localparam int HIST_N  = 4;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS       = 8'h00;
	localparam logic [7:0] STATUS_OFS     = 8'h04;
	localparam logic [7:0] START_DLY_OFS  = 8'h08;
	localparam logic [7:0] RUN_DLY_OFS    = 8'h0C;
	localparam logic [7:0] BRAKE_TIME_OFS = 8'h10;
	localparam logic [7:0] OA_LEVEL_OFS   = 8'h14;
	localparam logic [7:0] OA_TIME_OFS    = 8'h18;
	localparam logic [7:0] MODE_OFS       = 8'h1C;
	localparam logic [7:0] TIMING_A_OFS   = 8'h20;
	localparam logic [7:0] TIMING_B_OFS   = 8'h24;
	localparam logic [7:0] TRACE_OFS      = 8'h28;
	localparam logic [7:0] PEAK_OFS       = 8'h2C;
	localparam logic [7:0] TRAVEL_CNT_OFS = 8'h30;
	localparam logic [7:0] OP_TIME_OFS    = 8'h34;
	localparam logic [7:0] HIST_OFS       = 8'h40; // entry i: code +8i, time +8i+4
	localparam logic [7:0] HIST_END       = 8'h5C;
endpackage

// ==== verification/brake_model.sv ====
// brake actuator and feedback contact model for the fault supervisor bench
`timescale 1ns/10ps
module brake_model (
	input  wire logic clk_i,       // control clock
	input  wire logic brake_rel_i, // release command from the drive
	input  wire logic stuck_i,     // contact stuck, never reports release
	output logic      brake_fb_o   // high = brake released
);
	logic [2:0] lag_reg = 3'h0;    // shoe travel delay line
	// feedback lags the command by three clocks, well below one tick,
	// so a healthy brake never looks like a response error
	always_ff @(posedge clk_i) begin
		lag_reg <= {lag_reg[1:0], brake_rel_i};
	end
	// a stuck contact holds the applied reading whatever is commanded
	assign brake_fb_o = lag_reg[2] & ~stuck_i;
endmodule

// ==== verification/tb_elevator_fault_supervisor.sv ====
// self-checking bench for the elevator fault supervisor
`timescale 1ns/10ps
module tb_elevator_fault_supervisor;
	import fault_sup_pkg::*;
	localparam int TK = 10;          // clocks per ms tick, shortened
	logic        clk_i, reset_i;     // clock and reset
	logic        psel, penable;      // apb controls
	logic        pwrite;             // apb direction
	logic [7:0]  paddr;              // apb address
	logic [31:0] pwdata, prdata;     // apb data
	logic        pready, pslverr;    // apb answer
	logic        travel_cmd_i;       // travel command
	logic [7:0]  current_i, accel_i; // current and acceleration
	logic [15:0] speed_i;            // output speed
	logic        brake_fb, stuck;    // brake feedback and fault knob
	logic        ref_present_i;      // speed reference present
	logic        baseblock_i;        // baseblock input
	logic        safe_off_i;         // safe torque-off
	logic        drive_en_o, brake_rel_o, fault_o; // drive outputs
	int          err_count, n_compared;            // tallies

	fault_supervisor #(.TICK_CYCLES(TK)) dut (.clk_i(clk_i), .reset_i(reset_i),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.travel_cmd_i(travel_cmd_i), .current_i(current_i), .speed_i(speed_i),
		.accel_i(accel_i), .brake_fb_i(brake_fb), .ref_present_i(ref_present_i),
		.baseblock_i(baseblock_i), .safe_off_i(safe_off_i),
		.drive_en_o(drive_en_o), .brake_rel_o(brake_rel_o), .fault_o(fault_o));
	brake_model brake (.clk_i(clk_i), .brake_rel_i(brake_rel_o), .stuck_i(stuck),
		.brake_fb_o(brake_fb));

	// clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// verdict and end of run
	task end_sim;
		if (err_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// compare and count
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one apb transfer; an edge passes first so psel is never set twice at once
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic err);
		int n;
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			err_count++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	// masked read compared against an expectation
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input string nm);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		check(nm, q & m, x);
	endtask

	task ms(input int n);
		repeat (n * TK) @(posedge clk_i);
	endtask

	task flag(input string nm, input logic s, input logic x);
		check(nm, 32'(s), 32'(x));
	endtask

	// drop travel, clear the latched faults
	task rearm;
		travel_cmd_i <= 1'b0;
		wr(CTRL_OFS, 32'h1);
	endtask

	// hang guard, roughly twenty-five times the expected run
	initial begin
		repeat (30000) @(posedge clk_i);
		err_count++;
		end_sim;
	end

	// main sequence
	initial begin
		err_count = 0;
		n_compared = 0;
		{psel, penable, pwrite, travel_cmd_i, stuck, baseblock_i, safe_off_i} = 7'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		current_i = 8'h19;
		accel_i = 8'h00;
		speed_i = 16'h1234;
		ref_present_i = 1'b1;
		reset_i = 1'b1;
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		// defaults and a refused address
		rd(START_DLY_OFS, 32'hFFFF, 32'(START_DLY_RST), "start_dly");
		rd(RUN_DLY_OFS, 32'hFFFF, 32'(RUN_DLY_RST), "run_dly");
		rd(BRAKE_TIME_OFS, 32'hFFFF, 32'(BRAKE_TIME_RST), "brake_time");
		rd(OA_TIME_OFS, 32'hFFFF, 32'(OA_TIME_RST), "oa_time");
		rd(MODE_OFS, 32'h7F, 32'(MODE_RST), "mode");
		begin
			logic [31:0] q;
			logic e;
			apb(1'b0, 8'h3C, 32'h0, q, e);
			flag("pslverr", e, 1'b1);
		end
		// unit choice picks the level default
		wr(MODE_OFS, 32'h62);
		rd(OA_LEVEL_OFS, 32'hFF, 32'(OA_LEVEL_ALT), "oa_level alt");
		wr(MODE_OFS, 32'h02);
		rd(OA_LEVEL_OFS, 32'hFF, 32'(OA_LEVEL_STD), "oa_level std");
		// short timings; start delay is capped at timing_a - timing_b
		wr(TIMING_A_OFS, 32'd20);
		wr(TIMING_B_OFS, 32'd2);
		wr(START_DLY_OFS, 32'd50);
		rd(START_DLY_OFS, 32'hFFFF, 32'd18, "start_dly cap");
		wr(START_DLY_OFS, 32'd3);
		wr(RUN_DLY_OFS, 32'd3);
		wr(BRAKE_TIME_OFS, 32'd4);
		wr(OA_TIME_OFS, 32'd3);
		wr(OA_LEVEL_OFS, 32'd20);
		// normal start at exactly 25 %, then run current falls to 24 %
		travel_cmd_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		flag("drive_en", drive_en_o, 1'b1);
		ms(3);
		flag("brake early", brake_rel_o, 1'b0);
		ms(4);
		flag("brake release", brake_rel_o, 1'b1);
		repeat (3) begin
			current_i <= 8'h18;
			ms(1);
			current_i <= 8'h19;
			ms(1);
		end
		flag("no run fault", fault_o, 1'b0);
		current_i <= 8'h18;
		ms(5);
		flag("run fault", fault_o, 1'b1);
		flag("coast", drive_en_o, 1'b0);
		flag("brake drop", brake_rel_o, 1'b0);
		rd(STATUS_OFS, 32'h1F, 32'h02, "status run");
		rd(HIST_OFS, 32'hFF, 32'h2, "history run");
		rd(TRACE_OFS, 32'hFFFFFFFF, 32'h12341802, "trace run");
		rd(PEAK_OFS, 32'hFFFFFFFF, 32'h12340019, "peak");
		rd(TRAVEL_CNT_OFS, 32'hFFFF, 32'h1, "travel count");
		rearm;
		// starting current too low keeps the brake applied
		current_i <= 8'h0A;
		travel_cmd_i <= 1'b1;
		ms(7);
		flag("start fault", fault_o, 1'b1);
		flag("brake held", brake_rel_o, 1'b0);
		rd(STATUS_OFS, 32'h1F, 32'h01, "status start");
		rearm;
		// feedback never follows the release command
		current_i <= 8'h19;
		stuck <= 1'b1;
		travel_cmd_i <= 1'b1;
		ms(7);
		flag("brake wait", fault_o, 1'b0);
		ms(5);
		rd(STATUS_OFS, 32'h1F, 32'h04, "status brake");
		stuck <= 1'b0;
		rearm;
		// overacceleration at standstill, always-on mode
		accel_i <= 8'd30;
		ms(2);
		flag("oa wait", fault_o, 1'b0);
		ms(3);
		rd(STATUS_OFS, 32'h1F, 32'h08, "status oa");
		accel_i <= 8'h00;
		rearm;
		wr(MODE_OFS, 32'h03);
		accel_i <= 8'd30;
		ms(6);
		flag("oa run only", fault_o, 1'b0);
		wr(MODE_OFS, 32'h02);
		wr(OA_LEVEL_OFS, 32'h0);
		accel_i <= 8'hFF;
		ms(6);
		flag("oa disabled", fault_o, 1'b0);
		accel_i <= 8'h00;
		// reference loss, first with detection off
		wr(MODE_OFS, 32'h00);
		travel_cmd_i <= 1'b1;
		ref_present_i <= 1'b0;
		ms(2);
		flag("ref off", fault_o, 1'b0);
		wr(MODE_OFS, 32'h02);
		ms(1);
		rd(STATUS_OFS, 32'h1F, 32'h10, "status ref");
		ref_present_i <= 1'b1;
		rearm;
		// block with and without restart
		for (int i = 0; i < 4; i++) begin
			wr(MODE_OFS, i == 0 ? 32'h02 : i == 3 ? 32'h0E : 32'h06);
			travel_cmd_i <= 1'b1;
			ms(8);
			baseblock_i <= i < 2;
			safe_off_i <= i >= 2;
			ms(1);
			flag("blocked", drive_en_o, 1'b0);
			baseblock_i <= 1'b0;
			safe_off_i <= 1'b0;
			ms(1);
			flag("resume", drive_en_o, i == 1 || i == 3);
			travel_cmd_i <= 1'b0;
			ms(1);
		end
		// records survive init, cleared by their own control
		wr(CTRL_OFS, 32'h2);
		rd(HIST_OFS, 32'hFF, 32'h5, "history kept");
		rd(HIST_OFS + 8'h08, 32'hFF, 32'h4, "history older");
		rd(TRACE_OFS, 32'hFFFFFFFF, 32'h12341905, "trace kept");
		rd(START_DLY_OFS, 32'hFFFF, 32'(START_DLY_RST), "init");
		wr(CTRL_OFS, 32'h4);
		rd(HIST_OFS, 32'hFF, 32'h0, "history cleared");
		rd(TRACE_OFS, 32'hFFFFFFFF, 32'h0, "trace cleared");
		end_sim;
	end
endmodule

// ==== verilog/fault_supervisor.sv ====
// elevator drive fault supervisor with APB register access
//
// Functional notes
// - start current under 25% after delays faults
// - start delay defaults 200 ms, clamped
// - start current fault withholds brake release
// - run current under 25% after release faults
// - brake output/feedback disagreement for time faults
// - acceleration over level raises fault, coast
// - level zero disables overacceleration check
// - level default by display unit choice
// - overacceleration must persist programmed time
// - overacceleration check always, or running only
// - speed reference loss check when enabled
// - no restart after block when disabled
// - restart after block, safe-off needs setting
// - records survive parameter init, own clear
// - history keeps fault and operation time
// - peak current, its speed, travel count
// - any fault cuts output until cleared
`timescale 1ns/10ps
module fault_supervisor
	import fault_sup_pkg::*;
#(
	parameter int TICK_CYCLES = MS_TICK_CYCLES  // clocks per ms tick
)(
	input  wire logic        clk_i,         // control clock
	input  wire logic        reset_i,       // synchronous reset
	input  wire logic        psel,          // apb select
	input  wire logic        penable,       // apb access phase
	input  wire logic        pwrite,        // apb direction
	input  wire logic [7:0]  paddr,         // apb byte address
	input  wire logic [31:0] pwdata,        // apb write data
	output logic [31:0]      prdata,        // apb read data
	output logic             pready,        // apb ready
	output logic             pslverr,       // apb error on unmapped
	input  wire logic        travel_cmd_i,  // up/down command held
	input  wire logic [7:0]  current_i,     // output current, % rated
	input  wire logic [15:0] speed_i,       // output speed
	input  wire logic [7:0]  accel_i,       // car acceleration, 0.1 m/s2
	input  wire logic        brake_fb_i,    // brake feedback contact
	input  wire logic        ref_present_i, // speed reference present
	input  wire logic        baseblock_i,   // baseblock input active
	input  wire logic        safe_off_i,    // safe torque-off active
	output logic             drive_en_o,    // output stage enabled
	output logic             brake_rel_o,   // brake release command
	output logic             fault_o        // any fault latched
);
	// apb slave state
	logic        pready_reg, pslverr_reg;  // one wait state answer
	logic [31:0] prdata_reg;                 // captured read data
	// settings
	logic [13:0] start_dly_reg, run_dly_reg, brake_time_reg, oa_time_reg;
	logic [13:0] timing_a_reg, timing_b_reg; // start sequence timings
	logic [7:0]  oa_level_reg;                // 0.1 m/s2 units
	logic [6:0]  mode_reg;                    // selections
	// operation state
	logic [DIV_W-1:0] div_reg;               // ms divider
	logic        tick_reg;                   // one ms pulse
	logic        run_reg, brake_rel_reg;     // running, brake released
	logic        travel_prev_reg, blocked_prev_reg;
	logic        hold_reg;                   // travel held over a block
	logic        sto_seen_reg;               // block included safe-off
	logic [FLT_N-1:0] flags_reg;            // sticky faults
	logic        fault_reg;                  // any fault, registered for the pin
	// records
	logic [31:0] op_time_reg, travel_cnt_reg;
	logic [7:0]  peak_cur_reg, trace_cur_reg;
	logic [15:0] peak_spd_reg, trace_spd_reg;
	logic [2:0]  trace_code_reg;
	logic [2:0]  hist_code_reg [HIST_N];     // newest at index 0
	logic [31:0] hist_time_reg [HIST_N];

	// bus decode
	wire access    = psel && penable;
	wire wr_en     = access && pwrite && pready_reg;
	logic [31:0] rd_data;
	logic        rd_ok;
	wire wr_ctrl   = wr_en && paddr == CTRL_OFS;
	wire fault_clr = wr_ctrl && pwdata[CTRL_FAULT_CLR];
	wire par_init  = wr_ctrl && pwdata[CTRL_PARAM_INIT];
	wire rec_clr   = wr_ctrl && pwdata[CTRL_REC_CLR];
	wire [13:0] wd14 = pwdata[13:0];
	// start delay may not exceed timing a minus timing b
	wire [13:0] start_max = (timing_a_reg > timing_b_reg) ?
		timing_a_reg - timing_b_reg : 14'h0000;
	wire [2:0] unit_sel = mode_reg[MODE_UNIT_LSB +: 3];
	wire [7:0] oa_dflt  = (pwdata[MODE_UNIT_LSB +: 3] == UNIT_SEL_ALT) ?
		OA_LEVEL_ALT : OA_LEVEL_STD;

	// status and conditions
	wire fault_any = |flags_reg;
	wire blocked   = baseblock_i || safe_off_i;
	wire cur_low   = current_i < CURRENT_MIN_PCT;
	wire travel_rise = travel_cmd_i && !travel_prev_reg;
	wire block_end = blocked_prev_reg && !blocked;
	wire restart_ok = mode_reg[MODE_RESTART] &&
		(!sto_seen_reg || mode_reg[MODE_SAFE_DIS]);
	wire start_cond = run_reg && !brake_rel_reg && !fault_any;
	wire run_cond   = run_reg && brake_rel_reg && cur_low;
	wire brake_cond = run_reg && (brake_rel_reg != brake_fb_i);
	wire oa_cond = oa_level_reg != 8'h00 && accel_i > oa_level_reg &&
		(!mode_reg[MODE_OA_SEL] || run_reg);
	wire ref_cond = mode_reg[MODE_REF_EN] && run_reg && !ref_present_i;
	wire start_exp, run_exp, brake_exp, oa_exp;
	wire [FLT_N-1:0] det;
	// the timer result lags one cycle, so gate with the live condition
	// to keep a stale expiry from flagging after the brake has opened
	assign det[F_START] = start_exp && start_cond && cur_low;
	assign det[F_RUN]   = run_exp;
	assign det[F_BRAKE] = brake_exp;
	assign det[F_OACC]  = oa_exp;
	assign det[F_REF]   = ref_cond;
	wire [FLT_N-1:0] new_f = det & ~flags_reg;
	// set wins over a clear arriving in the same cycle
	wire [FLT_N-1:0] flags_next = (flags_reg & ~{FLT_N{fault_clr}}) | det;
	wire fault_new = |new_f;
	wire [2:0] new_code = new_f[F_START] ? 3'h1 : new_f[F_RUN] ? 3'h2 :
		new_f[F_BRAKE] ? 3'h3 : new_f[F_OACC] ? 3'h4 : 3'h5;

	// detection timers; start limit covers brake release time plus delay
	fault_timer u_start (.clk_i(clk_i), .reset_i(reset_i), .tick_i(tick_reg),
		.cond_i(start_cond), .limit_i({1'b0, timing_b_reg} + {1'b0, start_dly_reg}),
		.expired_o(start_exp));
	fault_timer u_run (.clk_i(clk_i), .reset_i(reset_i), .tick_i(tick_reg),
		.cond_i(run_cond), .limit_i({1'b0, run_dly_reg}), .expired_o(run_exp));
	fault_timer u_brake (.clk_i(clk_i), .reset_i(reset_i), .tick_i(tick_reg),
		.cond_i(brake_cond), .limit_i({1'b0, brake_time_reg}), .expired_o(brake_exp));
	fault_timer u_oacc (.clk_i(clk_i), .reset_i(reset_i), .tick_i(tick_reg),
		.cond_i(oa_cond), .limit_i({1'b0, oa_time_reg}), .expired_o(oa_exp));

	// read mux; unmapped addresses answer with an error
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok   = 1'b1;
		case (paddr)
			CTRL_OFS:       rd_data = 32'h0000_0000;
			STATUS_OFS:     rd_data = {25'h0, run_reg, brake_rel_reg, flags_reg};
			START_DLY_OFS:  rd_data = {18'h0, start_dly_reg};
			RUN_DLY_OFS:    rd_data = {18'h0, run_dly_reg};
			BRAKE_TIME_OFS: rd_data = {18'h0, brake_time_reg};
			OA_LEVEL_OFS:   rd_data = {24'h0, oa_level_reg};
			OA_TIME_OFS:    rd_data = {18'h0, oa_time_reg};
			MODE_OFS:       rd_data = {25'h0, mode_reg};
			TIMING_A_OFS:   rd_data = {18'h0, timing_a_reg};
			TIMING_B_OFS:   rd_data = {18'h0, timing_b_reg};
			TRACE_OFS:      rd_data = {trace_spd_reg, trace_cur_reg, 5'h00, trace_code_reg};
			PEAK_OFS:       rd_data = {peak_spd_reg, 8'h00, peak_cur_reg};
			TRAVEL_CNT_OFS: rd_data = travel_cnt_reg;
			OP_TIME_OFS:    rd_data = op_time_reg;
			default: begin
				if (paddr >= HIST_OFS && paddr <= HIST_END && paddr[1:0] == 2'b00) begin
					rd_data = paddr[2] ? hist_time_reg[paddr[4:3]] :
						{29'h0, hist_code_reg[paddr[4:3]]};
				end else begin
					rd_ok = 1'b0;
				end
			end
		endcase
	end

	// apb answer: ready one cycle into the access phase
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else begin
			pready_reg  <= access && !pready_reg;
			pslverr_reg <= access && !pready_reg && !rd_ok;
			if (access && !pready_reg && !pwrite) begin
				prdata_reg <= rd_data;
			end
		end
	end

	// settings; parameter init restores defaults and spares the records
	always_ff @(posedge clk_i) begin
		if (reset_i || par_init) begin
			start_dly_reg  <= START_DLY_RST;
			run_dly_reg    <= RUN_DLY_RST;
			brake_time_reg <= BRAKE_TIME_RST;
			oa_time_reg    <= OA_TIME_RST;
			oa_level_reg   <= OA_LEVEL_STD;
			mode_reg       <= MODE_RST;
			timing_a_reg   <= TIMING_A_RST;
			timing_b_reg   <= TIMING_B_RST;
		end else if (wr_en) begin
			case (paddr)
				START_DLY_OFS:  start_dly_reg <= (wd14 > start_max) ? start_max : wd14;
				RUN_DLY_OFS:    run_dly_reg <= (wd14 > RUN_DLY_MAX) ? RUN_DLY_MAX : wd14;
				BRAKE_TIME_OFS: brake_time_reg <= (wd14 > BRAKE_TIME_MAX) ?
					BRAKE_TIME_MAX : wd14;
				OA_TIME_OFS:    oa_time_reg <= (wd14 > OA_TIME_MAX) ? OA_TIME_MAX : wd14;
				OA_LEVEL_OFS:   oa_level_reg <= (pwdata[7:0] > OA_LEVEL_MAX) ?
					OA_LEVEL_MAX : pwdata[7:0];
				MODE_OFS: begin
					mode_reg <= pwdata[6:0];
					// a new unit choice reloads the level default
					if (pwdata[MODE_UNIT_LSB +: 3] != unit_sel) begin
						oa_level_reg <= oa_dflt;
					end
				end
				TIMING_A_OFS:   timing_a_reg <= wd14;
				TIMING_B_OFS:   timing_b_reg <= wd14;
				default: ;
			endcase
		end
	end

	// ms tick divider
	always_ff @(posedge clk_i) begin
		if (reset_i || div_reg == DIV_W'(TICK_CYCLES - 1)) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
		tick_reg <= !reset_i && div_reg == DIV_W'(TICK_CYCLES - 1);
	end

	// run sequencing and brake; a new detection beats a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			flags_reg        <= '0;
			fault_reg        <= 1'b0;
			run_reg          <= 1'b0;
			brake_rel_reg    <= 1'b0;
			travel_prev_reg  <= 1'b0;
			blocked_prev_reg <= 1'b0;
			hold_reg         <= 1'b0;
			sto_seen_reg     <= 1'b0;
		end else begin
			flags_reg        <= flags_next;
			fault_reg        <= |flags_next;
			travel_prev_reg  <= travel_cmd_i;
			blocked_prev_reg <= blocked;
			if (!travel_cmd_i || fault_any || fault_new) begin
				run_reg  <= 1'b0;
				hold_reg <= 1'b0;
			end else if (blocked) begin
				hold_reg     <= run_reg || hold_reg;
				sto_seen_reg <= safe_off_i || (sto_seen_reg && hold_reg);
				run_reg      <= 1'b0;
			end else if (travel_rise) begin
				run_reg <= 1'b1;
			end else if (block_end && hold_reg) begin
				run_reg  <= restart_ok;
				hold_reg <= 1'b0;
			end
			// brake opens only when the start check passes
			if (!run_reg || fault_any || fault_new) begin
				brake_rel_reg <= 1'b0;
			end else if (start_exp && start_cond && !cur_low) begin
				brake_rel_reg <= 1'b1;
			end
		end
	end

	// records: cleared by reset or record clear only, never by param init
	always_ff @(posedge clk_i) begin
		if (reset_i || rec_clr) begin
			op_time_reg    <= '0;
			travel_cnt_reg <= '0;
			peak_cur_reg   <= '0;
			peak_spd_reg   <= '0;
			trace_cur_reg  <= '0;
			trace_spd_reg  <= '0;
			trace_code_reg <= '0;
			for (int i = 0; i < HIST_N; i++) begin
				hist_code_reg[i] <= '0;
				hist_time_reg[i] <= '0;
			end
		end else begin
			if (tick_reg && run_reg) begin
				op_time_reg <= op_time_reg + 1'b1;
			end
			if (travel_rise) begin
				travel_cnt_reg <= travel_cnt_reg + 1'b1;
			end
			if (current_i > peak_cur_reg) begin
				peak_cur_reg <= current_i;
				peak_spd_reg <= speed_i;
			end
			if (fault_new) begin
				trace_code_reg   <= new_code;
				trace_cur_reg    <= current_i;
				trace_spd_reg    <= speed_i;
				hist_code_reg[0] <= new_code;
				hist_time_reg[0] <= op_time_reg;
				for (int i = 1; i < HIST_N; i++) begin
					hist_code_reg[i] <= hist_code_reg[i-1];
					hist_time_reg[i] <= hist_time_reg[i-1];
				end
			end
		end
	end

	assign prdata      = prdata_reg;
	assign pready      = pready_reg;
	assign pslverr     = pslverr_reg;
	assign drive_en_o  = run_reg;
	assign brake_rel_o = brake_rel_reg;
	assign fault_o     = fault_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	property p_start_fault;
		start_exp && start_cond && cur_low |=> flags_reg[F_START] && !brake_rel_reg;
	endproperty
	a_start_fault: assert property (p_start_fault) else $error("start fault missed");
	property p_brake_held;
		flags_reg[F_START] |=> !brake_rel_reg [*2];
	endproperty
	a_brake_held: assert property (p_brake_held) else $error("brake released");
	sequence s_fault_seen;
		fault_any ##1 1'b1;
	endsequence
	property p_coast;
		s_fault_seen |-> !run_reg && !brake_rel_reg;
	endproperty
	a_coast: assert property (p_coast) else $error("output on during fault");
	property p_oa_off;
		oa_level_reg == 8'h00 |-> !oa_cond;
	endproperty
	a_oa_off: assert property (p_oa_off) else $error("zero level checked");
	property p_oa_sel;
		mode_reg[MODE_OA_SEL] && !run_reg |-> !oa_cond;
	endproperty
	a_oa_sel: assert property (p_oa_sel) else $error("check active when stopped");
	property p_ref_off;
		!mode_reg[MODE_REF_EN] |=> !$rose(flags_reg[F_REF]);
	endproperty
	a_ref_off: assert property (p_ref_off) else $error("ref loss while off");
	property p_no_restart;
		!mode_reg[MODE_RESTART] && block_end && !travel_rise |=> !run_reg;
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("restart not allowed");
	property p_restart;
		restart_ok && hold_reg && block_end && travel_cmd_i && !fault_any && !fault_new
			|=> run_reg;
	endproperty
	a_restart: assert property (p_restart) else $error("restart missed");
	property p_init_keeps;
		par_init && !rec_clr && !fault_new |=> $stable(hist_code_reg[0]);
	endproperty
	a_init_keeps: assert property (p_init_keeps) else $error("history lost");
	property p_hist;
		fault_new && !rec_clr |=> hist_code_reg[0] == $past(new_code) &&
			hist_time_reg[0] == $past(op_time_reg);
	endproperty
	a_hist: assert property (p_hist) else $error("history not stored");
	property p_peak;
		current_i > peak_cur_reg && !rec_clr |=> peak_cur_reg == $past(current_i);
	endproperty
	a_peak: assert property (p_peak) else $error("peak not captured");
endmodule

// ==== verilog/fault_timer.sv ====
// detection delay timer: counts ms ticks while its condition holds
`timescale 1ns/10ps
module fault_timer
	import fault_sup_pkg::*;
(
	input  wire logic             clk_i,     // control clock
	input  wire logic             reset_i,   // synchronous reset
	input  wire logic             tick_i,    // one ms enable
	input  wire logic             cond_i,    // triggering condition
	input  wire logic [TMR_W-1:0] limit_i,   // programmed time in ms
	output logic                  expired_o  // condition held for limit
);
	logic [TMR_W-1:0] count_reg;  // elapsed ms
	logic             expired_reg;  // registered result

	// counter restarts whenever the condition drops
	always_ff @(posedge clk_i) begin
		if (reset_i || !cond_i) begin
			count_reg <= '0;
		end else if (tick_i && count_reg < limit_i) begin
			count_reg <= count_reg + 1'b1;
		end
	end

	// a zero limit expires one cycle after the condition first holds
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			expired_reg <= 1'b0;
		end else begin
			expired_reg <= cond_i && (count_reg >= limit_i);
		end
	end
	assign expired_o = expired_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	property p_restart;
		!cond_i |=> count_reg == '0 && !expired_reg;
	endproperty
	a_restart: assert property (p_restart) else $error("timer not restarted");
endmodule
